// ---- shared/mcs_pkg.sv ----
/*
  Constants shared by the channel slave adapter: register map, control and
  status field positions, reset values, cycle states and timing counts.
  Assumes a 200 MHz APB clock.
*/
package mcs_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BASE = 8'h04;
  localparam logic [7:0] OFF_WAIT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_STRHI = 8'h10;

  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SIZE_LO = 1;
  localparam int CTRL_RATE_LO = 3;
  localparam int CTRL_MUX = 5;
  localparam int CTRL_PAR = 6;
  localparam int CTRL_MEM = 7;
  localparam int CTRL_STRM = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [31:0] STRHI_RST = 32'h0000_0000;

  // Status register fields
  localparam int ST_PERR = 0;
  localparam int ST_RSV = 1;
  localparam int ST_OVR = 2;
  localparam int ST_BUSY = 3;

  // Port size codes in the control register
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Streaming rate line codes {rate0_n, rate1_n}
  localparam logic [1:0] RATE_BASIC = 2'h3;
  localparam logic [1:0] RATE_10MHZ = 2'h1;

  // Status line codes {status_line0_n, status_line1_n}
  localparam logic [1:0] STAT_WRITE = 2'h1;
  localparam logic [1:0] STAT_READ = 2'h2;
  localparam logic [1:0] STAT_IDLE = 2'h3;
  localparam logic [1:0] STAT_RSV = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int STRM_MIN_CYCLE_NS = 100;
  localparam int STRM_MIN_CYC = (STRM_MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_LAT_CYC = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_XFER = 2'b10,
    ST_HOLD = 2'b11
  } mcs_state_t;

endpackage

// ---- hw/mcs_sync.sv ----
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes each bit is a level; no bit crosses as a multi-bit word.
*/
`timescale 1ns/100ps
module mcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so no false strobe edge follows reset
      meta_reg <= INIT;
      dout <= INIT;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule

// ---- hw/mcs_mem.sv ----
/*
  Single-port word memory with byte write enables and registered read data.
  Assumes address and controls come from the pclk domain.
*/
`timescale 1ns/100ps
module mcs_mem #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);

  logic [31:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (we && be[i]) begin
        mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    rdata <= mem[addr];
  end

endmodule

// ---- hw/mcs_slave.sv ----
/*
  Expansion channel slave adapter: a memory or I/O slave with programmable
  port size, wait states, byte parity and streaming capability reporting.
  Assumes all channel pins are asynchronous to pclk; they pass two flops.
  The bidirectional pins are split into in/out/enable; the board resolves them.
*/
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module mcs_slave #(
  parameter int MEM_AW = 8,
  parameter int WAIT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] address_in,
  input wire logic mem_io_sel,
  input wire logic status_line0_n,
  input wire logic status_line1_n,
  input wire logic command_n,
  input wire logic address_latch_strobe_n,
  input wire logic [3:0] byte_lane_select_n,
  input wire logic high_byte_enable_n,
  input wire logic streaming_strobe_n,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [3:0] data_parity_bits_in,
  input wire logic data_parity_valid_in_n,
  output logic [3:0] data_parity_bits_out,
  output logic data_parity_valid_out_n,
  output logic parity_oe,
  output logic [3:0] address_parity_bits_out,
  output logic address_parity_oe,
  output logic slot_port_wide16_n,
  output logic slot_port_wide32_n,
  output logic slot_ready,
  output logic mux_streaming_request_n,
  output logic streaming_rate_req0_n,
  output logic streaming_rate_req1_n
);

  generate
    if (MEM_AW < 2 || MEM_AW > 20 || WAIT_W < 2 || WAIT_W > 16) begin : g_bad_param
      $error("mcs_slave: MEM_AW must be 2..20 and WAIT_W 2..16");
    end
  endgenerate

  // Synchronised pins
  localparam int SW = 80;
  logic [SW-1:0] pins_s;
  logic [31:0] addr_s;
  logic [31:0] data_s;
  logic [3:0] dpar_s;
  logic [3:0] be_n_s;
  logic mio_s, s0_s, s1_s, cmd_n_s, adl_n_s, high_byte_enable_n_n_s, strb_n_s, dpv_n_s;

  mcs_sync #(
    .W(SW),
    .INIT({32'h0000_0000, 1'b0, 4'hF, 4'hF, 2'h3, 32'h0000_0000, 4'h0, 1'b1})
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({address_in, mem_io_sel, status_line0_n, status_line1_n, command_n,
          address_latch_strobe_n, byte_lane_select_n, high_byte_enable_n,
          streaming_strobe_n, data_in, data_parity_bits_in, data_parity_valid_in_n}),
    .dout(pins_s)
  );

  assign {addr_s, mio_s, s0_s, s1_s, cmd_n_s, adl_n_s, be_n_s, high_byte_enable_n_n_s,
          strb_n_s, data_s, dpar_s, dpv_n_s} = pins_s;

  // Registers
  logic [8:0] ctrl_reg;
  logic [31:0] base_reg;
  logic [WAIT_W-1:0] wait_reg;
  logic [31:0] strhi_reg;
  logic perr_reg, rsv_reg, ovr_reg;
  mcs_pkg::mcs_state_t state_reg, state_next;
  logic [WAIT_W-1:0] cnt_reg;
  logic cmd_d_reg, adl_d_reg, strb_d_reg;
  logic [1:0] lat_st_reg;
  logic [1:0] lat_a_reg;
  logic [MEM_AW-1:0] lat_widx_reg;
  logic lat_high_byte_enable_n_n_reg;
  logic [3:0] lat_be_n_reg;
  logic strm_seen_reg;
  logic [7:0] gap_reg;

  // Control fields and unlatched decode
  wire en = ctrl_reg[mcs_pkg::CTRL_EN];
  wire [1:0] size = ctrl_reg[mcs_pkg::CTRL_SIZE_LO +: 2];
  wire [1:0] rate_cfg = ctrl_reg[mcs_pkg::CTRL_RATE_LO +: 2];
  wire par_en = ctrl_reg[mcs_pkg::CTRL_PAR];
  wire strm_en = ctrl_reg[mcs_pkg::CTRL_STRM];
  wire is32 = (size == mcs_pkg::SIZE_32);
  wire is16 = (size == mcs_pkg::SIZE_16);
  wire hit = en && (mio_s == ctrl_reg[mcs_pkg::CTRL_MEM])
             && (addr_s[31:MEM_AW+2] == base_reg[31:MEM_AW+2]);
  wire [1:0] st_code = {s0_s, s1_s};
  wire st_go = (st_code == mcs_pkg::STAT_WRITE) || (st_code == mcs_pkg::STAT_READ);
  wire start = hit && st_go;
  wire [WAIT_W-1:0] read_min = WAIT_W'(mcs_pkg::READ_LAT_CYC);
  wire is_rd_now = (st_code == mcs_pkg::STAT_READ);
  wire need_wait = is_rd_now || (wait_reg != '0);

  // Edges of synchronised strobes
  wire cmd_act = !cmd_n_s;
  wire cmd_rise = cmd_act && !cmd_d_reg;
  wire cmd_fall = !cmd_act && cmd_d_reg;
  wire adl_edge = adl_n_s != adl_d_reg;
  wire strb_fall = !strb_n_s && strb_d_reg;

  // Latched decode: the xor of the status lines marks a real command
  wire lat_cmd = lat_st_reg[1] ^ lat_st_reg[0];
  wire lat_rd = lat_cmd && lat_st_reg[1];
  wire lat_wr = lat_cmd && !lat_st_reg[1];

  // Lane enables and steering
  wire [3:0] be_w = is32 ? ~lat_be_n_reg
                  : is16 ? (lat_a_reg[1] ? {~lat_high_byte_enable_n_n_reg, ~lat_a_reg[0], 2'b00}
                                         : {2'b00, ~lat_high_byte_enable_n_n_reg, ~lat_a_reg[0]})
                  : (4'h1 << lat_a_reg);
  wire [31:0] wdata_w = is32 ? data_s : is16 ? {2{data_s[15:0]}} : {4{data_s[7:0]}};
  wire [31:0] mem_rdata;
  wire [7:0] rd_byte = 8'(mem_rdata >> {lat_a_reg, 3'b000});
  wire [15:0] rd_half = 16'(mem_rdata >> {lat_a_reg[1], 4'b0000});
  wire [31:0] rd_mux = is32 ? mem_rdata : is16 ? {16'h0000, rd_half} : {24'h00_0000, rd_byte};
  wire [3:0] rd_lanes = is32 ? 4'hF : is16 ? 4'h3 : 4'h1;

  // Byte odd parity of write data vs. received parity on enabled lanes
  wire [3:0] par_w = {~^data_s[31:24], ~^data_s[23:16], ~^data_s[15:8], ~^data_s[7:0]};
  wire [3:0] par_r = {~^rd_mux[31:24], ~^rd_mux[23:16], ~^rd_mux[15:8], ~^rd_mux[7:0]};
  wire in_xfer = (state_reg == mcs_pkg::ST_XFER);
  wire strm_step = in_xfer && strm_en && cmd_act && strb_fall;
  wire commit = in_xfer && lat_wr && ((cmd_fall && !strm_seen_reg) || strm_step);
  wire perr_evt = commit && !dpv_n_s && |(be_w & (dpar_s ^ par_w));
  wire rsv_evt = hit && (st_code == mcs_pkg::STAT_RSV);
  wire ovr_evt = strm_step && (rate_cfg == mcs_pkg::RATE_10MHZ)
                 && (gap_reg < 8'(mcs_pkg::STRM_MIN_CYC));

  mcs_mem #(.AW(MEM_AW)) u_mem (
    .pclk(pclk),
    .addr(lat_widx_reg),
    .we(commit),
    .be(be_w),
    .wdata(wdata_w),
    .rdata(mem_rdata)
  );

  // Size reporting straight from the unlatched decode; streaming capability straight from the control register
  assign slot_port_wide16_n = !(hit && (is16 || is32));
  assign slot_port_wide32_n = !(hit && is32);
  wire rate_ok = (rate_cfg == mcs_pkg::RATE_BASIC) || (rate_cfg == mcs_pkg::RATE_10MHZ);
  wire [1:0] rate_out = rate_ok ? rate_cfg : mcs_pkg::RATE_BASIC;
  assign streaming_rate_req0_n = rate_out[1];
  assign streaming_rate_req1_n = rate_out[0];
  // Only advertised while a streaming rate is advertised too
  assign mux_streaming_request_n = !(ctrl_reg[mcs_pkg::CTRL_MUX]
                                     && rate_out == mcs_pkg::RATE_10MHZ);
  // Ready drops in the same cycle the decode hits, not a cycle later
  assign slot_ready = !((state_reg == mcs_pkg::ST_WAIT)
                        || (state_reg == mcs_pkg::ST_IDLE && start && need_wait));

  // Cycle sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcs_pkg::ST_IDLE: begin
        if (start) begin
          state_next = need_wait ? mcs_pkg::ST_WAIT : mcs_pkg::ST_XFER;
        end
      end
      mcs_pkg::ST_WAIT: begin
        if (cnt_reg <= WAIT_W'(1)) begin
          state_next = mcs_pkg::ST_XFER;
        end
      end
      mcs_pkg::ST_XFER: begin
        if (cmd_fall) begin
          state_next = lat_rd ? mcs_pkg::ST_HOLD : mcs_pkg::ST_IDLE;
        end else if (!cmd_act && !st_go && !cmd_d_reg && !hit) begin
          state_next = mcs_pkg::ST_IDLE;
        end
      end
      mcs_pkg::ST_HOLD: state_next = mcs_pkg::ST_IDLE;
      default: state_next = mcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= mcs_pkg::ST_IDLE;
      cnt_reg <= '0;
      cmd_d_reg <= 1'b0;
      adl_d_reg <= 1'b1;
      strb_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cmd_d_reg <= cmd_act;
      adl_d_reg <= adl_n_s;
      strb_d_reg <= strb_n_s;
      if (state_reg == mcs_pkg::ST_IDLE) begin
        cnt_reg <= (is_rd_now && wait_reg < read_min) ? read_min : wait_reg;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - WAIT_W'(1);
      end
    end
  end

  // Address, status and lane latches
  wire lat_load = (state_reg == mcs_pkg::ST_IDLE && start) || cmd_rise || adl_edge;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_st_reg <= mcs_pkg::STAT_IDLE;
      lat_a_reg <= 2'h0;
      lat_widx_reg <= '0;
      lat_high_byte_enable_n_n_reg <= 1'b1;
      lat_be_n_reg <= 4'hF;
      strm_seen_reg <= 1'b0;
      gap_reg <= 8'h00;
    end else begin
      if (lat_load && !(in_xfer && cmd_d_reg)) begin
        lat_st_reg <= st_code;
        lat_a_reg <= addr_s[1:0];
        lat_widx_reg <= addr_s[MEM_AW+1:2];
        lat_high_byte_enable_n_n_reg <= high_byte_enable_n_n_s;
        lat_be_n_reg <= be_n_s;
      end else if (strm_step) begin
        lat_widx_reg <= lat_widx_reg + MEM_AW'(1);
      end
      if (state_reg == mcs_pkg::ST_IDLE) begin
        strm_seen_reg <= 1'b0;
      end else if (strm_step) begin
        strm_seen_reg <= 1'b1;
      end
      if (strm_step) begin
        gap_reg <= 8'h00;
      end else if (gap_reg != 8'hFF) begin
        gap_reg <= gap_reg + 8'h01;
      end
    end
  end

  // Read data drive: on in the transfer window, held one cycle past command end
  // The command-end cycle keeps driving too, so the bus never gaps before HOLD
  wire drive = lat_rd && ((in_xfer && (cmd_act || cmd_d_reg))
                          || state_reg == mcs_pkg::ST_HOLD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 32'h0000_0000;
      data_oe <= 1'b0;
      data_parity_bits_out <= 4'h0;
      data_parity_valid_out_n <= 1'b1;
      parity_oe <= 1'b0;
      address_parity_bits_out <= 4'h0;
      address_parity_oe <= 1'b0;
    end else begin
      data_oe <= drive;
      if (drive && state_reg != mcs_pkg::ST_HOLD) begin
        data_out <= rd_mux;
        data_parity_bits_out <= par_r | ~rd_lanes;
      end
      parity_oe <= drive && par_en;
      data_parity_valid_out_n <= !(drive && par_en);
      address_parity_bits_out <= {~^strhi_reg[31:24], ~^strhi_reg[23:16],
                                  ~^strhi_reg[15:8], ~^strhi_reg[7:0]};
      address_parity_oe <= drive && par_en && strm_en;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == mcs_pkg::OFF_CTRL;
  wire hit_base = paddr == mcs_pkg::OFF_BASE;
  wire hit_wait = paddr == mcs_pkg::OFF_WAIT;
  wire hit_stat = paddr == mcs_pkg::OFF_STATUS;
  wire hit_strhi = paddr == mcs_pkg::OFF_STRHI;
  wire map_hit = hit_ctrl || hit_base || hit_wait || hit_stat || hit_strhi;
  wire busy = state_reg != mcs_pkg::ST_IDLE;
  wire [31:0] stat_word = {28'h000_0000, busy, ovr_reg, rsv_reg, perr_reg};
  wire [31:0] rd_sel = hit_ctrl ? {23'h00_0000, ctrl_reg}
                     : hit_base ? base_reg
                     : hit_wait ? 32'(wait_reg)
                     : hit_stat ? stat_word
                     : hit_strhi ? strhi_reg : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= mcs_pkg::CTRL_RST;
      base_reg <= mcs_pkg::BASE_RST;
      wait_reg <= '0;
      strhi_reg <= mcs_pkg::STRHI_RST;
      prdata <= 32'h0000_0000;
      perr_reg <= 1'b0;
      rsv_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      if (psel && !penable) begin
        prdata <= rd_sel;
      end
      if (apb_wr && hit_ctrl) ctrl_reg <= pwdata[8:0];
      if (apb_wr && hit_base) base_reg <= pwdata;
      if (apb_wr && hit_wait) wait_reg <= pwdata[WAIT_W-1:0];
      if (apb_wr && hit_strhi) strhi_reg <= pwdata;
      // Write one to clear; a new event in the same cycle keeps the flag set
      perr_reg <= perr_evt || (perr_reg && !(apb_wr && hit_stat && pwdata[mcs_pkg::ST_PERR]));
      rsv_reg <= rsv_evt || (rsv_reg && !(apb_wr && hit_stat && pwdata[mcs_pkg::ST_RSV]));
      ovr_reg <= ovr_evt || (ovr_reg && !(apb_wr && hit_stat && pwdata[mcs_pkg::ST_OVR]));
    end
  end

  // Checks
  sequence s_wait_start;
    state_reg == mcs_pkg::ST_IDLE && start && need_wait;
  endsequence
  sequence s_ready_low2;
    !slot_ready ##1 !slot_ready;
  endsequence

  property p_wide32_with16;
    @(posedge pclk) disable iff (!presetn) !slot_port_wide32_n |-> !slot_port_wide16_n;
  endproperty
  a_wide32_with16: assert property (p_wide32_with16) else $error("wide32 without wide16");

  property p_size8_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!is16 && !is32) |-> (slot_port_wide16_n && slot_port_wide32_n);
  endproperty
  a_size8_quiet: assert property (p_size8_quiet) else $error("8-bit port drives size");

  property p_ready_wait;
    @(posedge pclk) disable iff (!presetn) s_wait_start |-> s_ready_low2;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready not held low");

  property p_idle_no_drive;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == mcs_pkg::ST_IDLE && $past(state_reg) == mcs_pkg::ST_IDLE) |-> !data_oe;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive) else $error("data driven idle");

  property p_read_parity;
    @(posedge pclk) disable iff (!presetn)
      (data_oe && rd_lanes == 4'hF) |->
        data_parity_bits_out == {~^data_out[31:24], ~^data_out[23:16],
                                 ~^data_out[15:8], ~^data_out[7:0]};
  endproperty
  a_read_parity: assert property (p_read_parity) else $error("read parity wrong");

  property p_hold_after_cmd;
    @(posedge pclk) disable iff (!presetn) (in_xfer && lat_rd && cmd_fall) |=> data_oe;
  endproperty
  a_hold_after_cmd: assert property (p_hold_after_cmd) else $error("read data dropped");

  property p_rate_legal;
    @(posedge pclk) disable iff (!presetn)
      !(streaming_rate_req1_n == 1'b0);
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("reserved rate code");

  property p_mux_needs_rate;
    @(posedge pclk) disable iff (!presetn) !mux_streaming_request_n |-> !streaming_rate_req0_n;
  endproperty
  a_mux_needs_rate: assert property (p_mux_needs_rate) else $error("mux request alone");

  property p_ready_then_data;
    @(posedge pclk) disable iff (!presetn)
      ($rose(slot_ready) && lat_rd && cmd_act) |-> ##[1:3] data_oe;
  endproperty
  a_ready_then_data: assert property (p_ready_then_data) else $error("no data after ready");

  property p_dpv_with_data;
    @(posedge pclk) disable iff (!presetn) !data_parity_valid_out_n |-> (data_oe && parity_oe);
  endproperty
  a_dpv_with_data: assert property (p_dpv_with_data) else $error("parity valid w/o data");

endmodule

// ---- testbench/mcs_chan_master.sv ----
/*
  Channel master model: drives address, status, command and write data.
  Assumes one slot, so the ready return is that slot's ready line.
*/
`timescale 1ns/100ps
module mcs_chan_master (
  input wire logic pclk,
  input wire logic slot_ready,
  input wire logic read_drive,
  input wire logic [31:0] data_bus,
  input wire logic [3:0] parity_bus,
  output logic [31:0] address_in,
  output logic mem_io_sel,
  output logic status_line0_n,
  output logic status_line1_n,
  output logic command_n,
  output logic address_latch_strobe_n,
  output logic [3:0] byte_lane_select_n,
  output logic high_byte_enable_n,
  output logic streaming_strobe_n,
  output logic [31:0] data_m,
  output logic [3:0] data_parity_bits_in,
  output logic data_parity_valid_in_n
);
  initial begin
    address_in = 32'h0000_0000;
    mem_io_sel = 1'b1;
    {status_line0_n, status_line1_n} = mcs_pkg::STAT_IDLE;
    command_n = 1'b1;
    address_latch_strobe_n = 1'b1;
    byte_lane_select_n = 4'hF;
    high_byte_enable_n = 1'b1;
    streaming_strobe_n = 1'b1; // Basic cycles only
    data_m = 32'h0000_0000;
    data_parity_bits_in = 4'hF;
    data_parity_valid_in_n = 1'b1;
  end
  task automatic set_addr(input logic [31:0] a);
    @(posedge pclk);
    address_in <= a;
  endtask
  // Ready return is the AND of one slot line
  task automatic run(input logic [1:0] st, input logic [31:0] a, input logic [3:0] ln,
      input logic [31:0] wd, output logic [31:0] rd, output logic [3:0] rp,
      output int lowcnt, output logic ok);
    int n;
    lowcnt = 0;
    ok = 1'b0;
    @(posedge pclk);
    address_in <= a;
    {status_line0_n, status_line1_n} <= st;
    byte_lane_select_n <= ln;
    data_m <= (st == mcs_pkg::STAT_READ) ? ~data_m : wd;
    data_parity_bits_in <= {~^wd[31:24], ~^wd[23:16], ~^wd[15:8], ~^wd[7:0]};
    data_parity_valid_in_n <= (st == mcs_pkg::STAT_READ);
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge pclk);
      if (n == 3) command_n <= 1'b0;
      if (slot_ready === 1'b0) lowcnt++;
      else if (n > 8 && (st != mcs_pkg::STAT_READ || read_drive === 1'b1)) ok = 1'b1;
    end
    rd = data_bus;
    rp = parity_bus;
    command_n <= 1'b1;
    // Status drops with the strobe, so the slave cannot see a second cycle start
    {status_line0_n, status_line1_n} <= mcs_pkg::STAT_IDLE;
    // Write data outlives the strobe so the synchronised copy is still valid
    repeat (4) @(posedge pclk);
    data_m <= ~data_m;
    data_parity_valid_in_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- testbench/tb_mcs_slave.sv ----
/*
  Bench for the channel slave: set-up over APB, cycles by the master model.
  Assumes a single slot; the data and parity buses are resolved here.
*/
`timescale 1ns/100ps
module tb_mcs_slave;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_oe, parity_oe, ok, err;
  logic mem_io_sel, status_line0_n, status_line1_n, command_n, address_latch_strobe_n;
  logic high_byte_enable_n, streaming_strobe_n, data_parity_valid_in_n, slot_ready;
  logic slot_port_wide16_n, slot_port_wide32_n, mux_streaming_request_n;
  logic streaming_rate_req0_n, streaming_rate_req1_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, address_in, data_in, data_out, data_m, rd, rv;
  logic [3:0] byte_lane_select_n, mpar, data_parity_bits_out, par_bus, rp;
  int num_errors, checks_done, lowcnt, i;
  logic [3:0] apar;
  logic apar_oe, dpv_out_n;
  wire port_wide16_return_n, port_wide32_return_n;
  wire [1:0] port_size;
  assign data_in = data_oe ? data_out : data_m;
  assign par_bus = parity_oe ? data_parity_bits_out : mpar;
  // One slot: each wired-AND return is just that slot's own line
  assign port_wide16_return_n = slot_port_wide16_n;
  assign port_wide32_return_n = slot_port_wide32_n;
  // Code 3 marks the invalid 32-only pattern
  assign port_size = port_wide16_return_n ? (port_wide32_return_n ? 2'h0 : 2'h3)
                                          : (port_wide32_return_n ? 2'h1 : 2'h2);
  mcs_slave dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .address_in, .mem_io_sel, .status_line0_n, .status_line1_n, .command_n,
    .address_latch_strobe_n, .byte_lane_select_n, .high_byte_enable_n, .streaming_strobe_n,
    .data_in, .data_out, .data_oe, .data_parity_bits_in(par_bus), .data_parity_valid_in_n,
    .data_parity_bits_out, .data_parity_valid_out_n(dpv_out_n), .parity_oe,
    .address_parity_bits_out(apar), .address_parity_oe(apar_oe), .slot_port_wide16_n,
    .slot_port_wide32_n, .slot_ready, .mux_streaming_request_n, .streaming_rate_req0_n,
    .streaming_rate_req1_n);
  mcs_chan_master u_m (.pclk, .slot_ready, .read_drive(data_oe), .data_bus(data_in),
    .parity_bus(par_bus), .address_in, .mem_io_sel, .status_line0_n, .status_line1_n,
    .command_n, .address_latch_strobe_n, .byte_lane_select_n, .high_byte_enable_n,
    .streaming_strobe_n, .data_m, .data_parity_bits_in(mpar), .data_parity_valid_in_n);
  always #2.5 pclk = ~pclk;
  task automatic test_done;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check(32'(slot_ready), 32'h1, "ready at rest");
    check(32'({slot_port_wide16_n, slot_port_wide32_n}), 32'h3, "size idle");
    apb(1'b0, mcs_pkg::OFF_CTRL, 32'h0);
    check(rv, 32'h0, "ctrl reset");
    apb(1'b1, 8'h40, 32'h5);
    check(32'(err), 32'h1, "unmapped");
    apb(1'b1, mcs_pkg::OFF_BASE, 32'h0000_0400);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, mcs_pkg::OFF_CTRL, 32'h0000_00E9 | 32'(i << 1));
      u_m.set_addr(32'h0000_0408);
      repeat (4) @(posedge pclk);
      check(32'({slot_port_wide16_n, slot_port_wide32_n}), 32'(2 - i + (i == 0)), "size");
      check(32'(port_size), 32'(i), "decoded size");
    end
    check(32'({streaming_rate_req0_n, streaming_rate_req1_n, mux_streaming_request_n}),
      32'h2, "rate");
    u_m.set_addr(32'h0000_0808);
    repeat (4) @(posedge pclk);
    check(32'({slot_port_wide16_n, slot_port_wide32_n}), 32'h3, "no decode");
    apb(1'b1, mcs_pkg::OFF_WAIT, 32'h0);
    u_m.run(mcs_pkg::STAT_WRITE, 32'h0000_0408, 4'h0, 32'hA5C3_1E7F, rd, rp, lowcnt, ok);
    check(32'({ok, lowcnt == 0}), 32'h3, "write no wait");
    u_m.run(mcs_pkg::STAT_WRITE, 32'h0000_0408, 4'hC, 32'h0F0F_6699, rd, rp, lowcnt, ok);
    check(32'(ok), 32'h1, "lane write");
    apb(1'b1, mcs_pkg::OFF_WAIT, 32'h4);
    apb(1'b0, mcs_pkg::OFF_WAIT, 32'h0);
    check(rv, 32'h4, "wait reg");
    u_m.run(mcs_pkg::STAT_READ, 32'h0000_0408, 4'h0, 32'h0, rd, rp, lowcnt, ok);
    check(32'({ok, lowcnt >= 4 && lowcnt <= 5}), 32'h3, "read wait");
    check(rd, 32'hA5C3_6699, "read data");
    check(32'(rp), 32'({~^8'hA5, ~^8'hC3, ~^8'h66, ~^8'h99}), "parity");
    for (i = 0; i < 2; i++) begin
      u_m.run(i == 0 ? mcs_pkg::STAT_RSV : mcs_pkg::STAT_IDLE, 32'h0000_0408, 4'h0,
        32'h1234_5678, rd, rp, lowcnt, ok);
      apb(1'b0, mcs_pkg::OFF_STATUS, 32'h0);
      check(32'(rv[mcs_pkg::ST_RSV]), 32'(i == 0), "reserved flag");
      apb(1'b1, mcs_pkg::OFF_STATUS, 32'h2);
    end
    apb(1'b1, mcs_pkg::OFF_STRHI, 32'h0103_0708);
    u_m.run(mcs_pkg::STAT_READ, 32'h0000_0408, 4'h0, 32'h0, rd, rp, lowcnt, ok);
    check(rd, 32'hA5C3_6699, "no store");
    check(32'({dpv_out_n, apar_oe, apar}),
      32'({1'b1, 1'b0, ~^8'h01, ~^8'h03, ~^8'h07, ~^8'h08}), "addr parity");
    test_done();
  end
endmodule
